// ==== link_recovery_fsm.sv ====
// port state machine for link recovery and primitive sequence transmit
// assumes loss_of_signal is asynchronous; all other inputs on sys_clk
//
// Behaviour
// - once offline sequence starts, send it at least 5 ms before acting
// - send offline on init, on recognised not-operational, or going offline
// - go offline only for diagnostics or power down
// - send link reset to start reset, on timeout, or unknown connection
// - send reset response while recognising link reset
// - unlisted conditions keep the current state
// - active entered when init or reset completes; frames pass there
// - active: LR, NOS, OLS move on; idles, ready, frames stay
// - reset response in active enters LRR receive and counts error
// - LR transmit sends LR; LR, LRR, NOS, OLS move; idle stays
// - recovery state held past timeout flags failure, enters NOS transmit
// - loss of signal in recovery states enters NOS transmit
// - link reset removes connection, reloads end-to-end credit
// - link reset aborts class 1 sequences; discard class 1 while sending
// - sending LR reloads buffer credit; fabric port flushes held frames
// - LR recognised enters LR receive unless wait-OLS, NOS transmit or offline
// - LR receive: LR stays, LRR, NOS, OLS move, idles go active
// - recognising LR flushes receive buffers, reloads buffer credit
// - LRR entered from active, LR states, OLS receive; sends idles
// - LRR receive: LR, NOS, OLS move, LRR stays, idles go active
// - NOS transmit and receive ignore reset response
// - wait-OLS moves to NOS transmit on reset response
// - sequence recognised after three identical sets without data
// - a sequence is sent without break while its condition lasts
// - NOS transmit sends not-operational continuously
`timescale 1ns/1ps
module link_recovery_fsm
   import fc_link_pkg::*;
#(
   parameter int unsigned OLS_MIN  = OLS_MIN_CYC,
   parameter int unsigned RTT      = RTT_CYC,
   parameter bit          IS_FPORT = 1'b0,
   parameter bit          CLASS1_N = 1'b1
) (
   input  wire logic  sys_clk,
   input  wire logic  rst,
   input  wire logic  os_valid,
   input  os_code_t   os_code,
   input  wire logic  data_ind,
   input  wire logic  loss_of_signal,
   input  wire logic  link_init_req,
   input  wire logic  diag_req,
   input  wire logic  power_down_req,
   input  wire logic  link_reset_req,
   input  wire logic  link_timeout_req,
   input  wire logic  conn_unknown_req,
   output tx_sel_t    tx_sel,
   output port_state_t port_state,
   output logic       link_fail,
   output logic       rtt_timeout,
   output logic       lesb_proto_err,
   output logic       conn_remove,
   output logic       ee_credit_reload,
   output logic       bb_credit_reload,
   output logic       class1_abort,
   output logic       class1_discard,
   output logic       rx_flush
);
   localparam logic [TIMER_W-1:0] OLS_LIM = TIMER_W'(OLS_MIN);
   localparam logic [TIMER_W-1:0] RTT_LIM = TIMER_W'(RTT);
   localparam logic [TIMER_W-1:0] TM_ONE  = TIMER_W'(1);

   generate
      if (OLS_MIN < 1 || RTT < 1) begin : g_bad
         $error("timer counts must be at least one cycle");
      end
   endgenerate

   function automatic logic in_recovery(input port_state_t s);
      return (s == ST_LR_TX) || (s == ST_LR_RX) || (s == ST_LRR_RX);
   endfunction : in_recovery

   function automatic tx_sel_t tx_for(input port_state_t s);
      case (s)
         ST_LR_TX:    return TX_LR;
         ST_LR_RX:    return TX_LRR;
         ST_NOS_TX:   return TX_NOS;
         ST_WAIT_OLS: return TX_NOS;
         ST_NOS_RX:   return TX_OLS;
         ST_OLS_TX:   return TX_OLS;
         ST_OLS_RX:   return TX_LR;
         default:     return TX_IDLE;
      endcase
   endfunction : tx_for

   seq_rec_if rec ();

   seq_recognizer #(
      .REC_N (REC_COUNT)
   ) u_rec (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .os_valid (os_valid),
      .os_code  (os_code),
      .data_ind (data_ind),
      .rec      (rec.src)
   );

   // loss of signal synchroniser
   logic los_m_q;
   logic los_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         los_m_q <= 1'b0;
         los_q   <= 1'b0;
      end else begin
         los_m_q <= loss_of_signal;
         los_q   <= los_m_q;
      end
   end

   logic rec_lr, rec_lrr, rec_nos, rec_ols, rec_idle;
   assign rec_lr   = rec.rec_valid && rec.rec_code == OS_LR;
   assign rec_lrr  = rec.rec_valid && rec.rec_code == OS_LRR;
   assign rec_nos  = rec.rec_valid && rec.rec_code == OS_NOS;
   assign rec_ols  = rec.rec_valid && rec.rec_code == OS_OLS;
   assign rec_idle = rec.rec_valid && rec.rec_code == OS_IDLE;

   port_state_t        state_q, state_d;
   logic               init_rsn_q, init_rsn_d;
   logic               restart;
   logic [TIMER_W-1:0] tm_q;
   logic               off_req, lr_start, tmo, hold_done;

   assign off_req   = diag_req || power_down_req;
   assign lr_start  = link_reset_req || link_timeout_req ||
                      (CLASS1_N && conn_unknown_req);
   assign tmo       = in_recovery(state_q) && tm_q >= RTT_LIM;
   assign hold_done = tm_q >= OLS_LIM;

   always_comb begin
      state_d    = state_q;
      init_rsn_d = init_rsn_q;
      restart    = 1'b0;
      case (state_q)
         ST_ACTIVE: begin
            if (los_q)              state_d = ST_NOS_TX;
            else if (rec_lr)        state_d = ST_LR_RX;
            else if (rec_lrr)       state_d = ST_LRR_RX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
            else if (link_init_req || off_req) begin
               state_d    = ST_OLS_TX;
               init_rsn_d = link_init_req;
            end else if (lr_start)  state_d = ST_LR_TX;
         end
         ST_LR_TX: begin
            if (los_q || tmo)       state_d = ST_NOS_TX;
            else if (rec_lr)        state_d = ST_LR_RX;
            else if (rec_lrr)       state_d = ST_LRR_RX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
         end
         ST_LR_RX: begin
            if (los_q || tmo)       state_d = ST_NOS_TX;
            else if (rec_lrr)       state_d = ST_LRR_RX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
            else if (rec_idle)      state_d = ST_ACTIVE;
         end
         ST_LRR_RX: begin
            if (los_q || tmo)       state_d = ST_NOS_TX;
            else if (rec_lr)        state_d = ST_LR_RX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
            else if (rec_idle)      state_d = ST_ACTIVE;
         end
         ST_NOS_TX: begin
            if (!los_q) begin
               if (rec_nos)         state_d = ST_NOS_RX;
               else if (rec_ols)    state_d = ST_OLS_RX;
               else if (link_init_req || off_req) begin
                  state_d    = ST_OLS_TX;
                  init_rsn_d = link_init_req;
               end
            end
         end
         ST_NOS_RX: begin
            if (los_q)              state_d = ST_NOS_TX;
            else if (rec_lr)        state_d = ST_LR_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
            else if (link_init_req || off_req) begin
               state_d    = ST_OLS_TX;
               init_rsn_d = link_init_req;
            end
         end
         ST_OLS_TX: begin
            if (!hold_done) begin
               state_d = ST_OLS_TX;
            end else if (init_rsn_q) begin
               if (rec_lr)          state_d = ST_LR_RX;
               else if (rec_nos)    state_d = ST_NOS_RX;
               else if (rec_ols)    state_d = ST_OLS_RX;
               else if (tm_q >= OLS_LIM + RTT_LIM) state_d = ST_WAIT_OLS;
            end else if (link_init_req) begin
               init_rsn_d = 1'b1;
               restart    = 1'b1;
            end
         end
         ST_OLS_RX: begin
            if (los_q)              state_d = ST_WAIT_OLS;
            else if (rec_lr)        state_d = ST_LR_RX;
            else if (rec_lrr)       state_d = ST_LRR_RX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (off_req) begin
               state_d    = ST_OLS_TX;
               init_rsn_d = 1'b0;
            end
         end
         ST_WAIT_OLS: begin
            if (rec_lr || rec_lrr)  state_d = ST_NOS_TX;
            else if (rec_nos)       state_d = ST_NOS_RX;
            else if (rec_ols)       state_d = ST_OLS_RX;
         end
         default: begin
            state_d = STATE_RST;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q    <= STATE_RST;
         init_rsn_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         init_rsn_q <= init_rsn_d;
      end
   end

   // state timer, cleared on every entry
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tm_q <= '0;
      end else if (state_d != state_q || restart) begin
         tm_q <= '0;
      end else if (tm_q != '1) begin
         tm_q <= tm_q + TM_ONE;
      end
   end

   // transmitted word follows the next state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_sel <= TX_SEL_RST;
      end else begin
         tx_sel <= tx_for(state_d);
      end
   end
   assign port_state = state_q;

   logic changed, enter_lr_tx, enter_lr_rx;
   assign changed     = state_d != state_q;
   assign enter_lr_tx = changed && state_d == ST_LR_TX;
   assign enter_lr_rx = changed && state_d == ST_LR_RX;

   // link reset side effects, one pulse per entry; class1_discard held through LR transmit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conn_remove      <= 1'b0;
         ee_credit_reload <= 1'b0;
         bb_credit_reload <= 1'b0;
         class1_abort     <= 1'b0;
         rx_flush         <= 1'b0;
         class1_discard   <= 1'b0;
      end else begin
         conn_remove      <= enter_lr_tx || enter_lr_rx;
         ee_credit_reload <= enter_lr_tx || enter_lr_rx;
         bb_credit_reload <= enter_lr_tx || enter_lr_rx;
         class1_abort     <= enter_lr_tx || enter_lr_rx;
         rx_flush         <= enter_lr_rx ||
                             (IS_FPORT && enter_lr_tx);
         class1_discard   <= state_d == ST_LR_TX;
      end
   end

   // error reporting pulses
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         link_fail      <= 1'b0;
         rtt_timeout    <= 1'b0;
         lesb_proto_err <= 1'b0;
      end else begin
         link_fail      <= changed && (state_d == ST_NOS_TX ||
                                       state_d == ST_NOS_RX);
         rtt_timeout    <= tmo && !los_q;
         lesb_proto_err <= state_q == ST_ACTIVE &&
                           state_d == ST_LRR_RX;
      end
   end

   ols_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_OLS_TX && tm_q < OLS_LIM) |=> state_q == ST_OLS_TX)
      else $error("offline sequence left before minimum time");

   lrr_send_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_LR_RX) |-> tx_sel == TX_LRR)
      else $error("LR receive not sending reset response");

   rtt_expire_a: assert property (@(posedge sys_clk) disable iff (rst)
      (in_recovery(state_q) && tm_q >= RTT_LIM)
      |=> (state_q == ST_NOS_TX && link_fail))
      else $error("recovery timeout did not enter NOS transmit");

   los_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
      (in_recovery(state_q) && los_q) |=> state_q == ST_NOS_TX ##0
      tx_sel == TX_NOS)
      else $error("loss of signal ignored in recovery state");

   proto_err_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_ACTIVE && rec_lrr && !los_q && !rec_lr)
      |=> (state_q == ST_LRR_RX && lesb_proto_err && tx_sel == TX_IDLE))
      else $error("reset response in active not counted");

   nos_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
      ((state_q == ST_NOS_TX || state_q == ST_NOS_RX) && rec_lrr &&
       !los_q && !link_init_req && !off_req) |=> $stable(state_q))
      else $error("NOS state reacted to reset response");

   wait_lrr_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_WAIT_OLS && rec_lrr) |=> state_q == ST_NOS_TX)
      else $error("wait state missed reset response");

   lr_effect_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q != ST_LR_TX ##1 state_q == ST_LR_TX)
      |-> (conn_remove && bb_credit_reload && class1_discard))
      else $error("LR transmit entry without credit reload");

   lr_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
      ((state_q == ST_ACTIVE || state_q == ST_LRR_RX ||
        state_q == ST_OLS_RX) && rec_lr && !los_q && !tmo)
      |=> (state_q == ST_LR_RX && rx_flush) ##1
      (state_q != ST_LR_RX || !rx_flush))
      else $error("recognised LR did not enter LR receive");

   idle_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_LRR_RX && rec_idle && !los_q && !tmo)
      |=> state_q == ST_ACTIVE)
      else $error("idles in LRR receive did not reach active");

endmodule : link_recovery_fsm

// ==== fc_link_pkg.sv ====
// shared types, timing counts and reset values for the link recovery port
// assumes a single 20 MHz word clock for every user of the package
package fc_link_pkg;

   // ordered sets as classified by the word decoder
   typedef enum logic [3:0] {
      OS_IDLE  = 4'h0,
      OS_RRDY  = 4'h1,
      OS_NOS   = 4'h2,
      OS_OLS   = 4'h3,
      OS_LR    = 4'h4,
      OS_LRR   = 4'h5,
      OS_SOF   = 4'h6,
      OS_EOF   = 4'h7,
      OS_OTHER = 4'h8
   } os_code_t;

   typedef enum logic [3:0] {
      ST_ACTIVE   = 4'h0,
      ST_LR_TX    = 4'h1,
      ST_LR_RX    = 4'h2,
      ST_LRR_RX   = 4'h3,
      ST_NOS_TX   = 4'h4,
      ST_NOS_RX   = 4'h5,
      ST_OLS_TX   = 4'h6,
      ST_OLS_RX   = 4'h7,
      ST_WAIT_OLS = 4'h8
   } port_state_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_NOS  = 3'h1,
      TX_OLS  = 3'h2,
      TX_LR   = 3'h3,
      TX_LRR  = 3'h4
   } tx_sel_t;

   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned OLS_MIN_NS    = 5000000;
   localparam int unsigned R_T_TOV_NS    = 100000000;
   localparam int unsigned OLS_MIN_CYC   =
      (OLS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RTT_CYC       =
      (R_T_TOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REC_COUNT     = 3;
   localparam int unsigned TIMER_W       = 32;

   localparam port_state_t STATE_RST  = ST_OLS_TX;
   localparam tx_sel_t     TX_SEL_RST = TX_OLS;

endpackage : fc_link_pkg

// ==== seq_rec_if.sv ====
// recognised ordered set report from the recogniser to the port machine
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface seq_rec_if;
   import fc_link_pkg::*;
   logic     rec_valid;
   os_code_t rec_code;
   modport src (output rec_valid, output rec_code);
   modport dst (input rec_valid, input rec_code);
endinterface : seq_rec_if

// ==== seq_recognizer.sv ====
// ordered set recogniser: single sets for signals, runs for sequences
// assumes os_valid, os_code and data_ind come from logic on sys_clk
`timescale 1ns/1ps
module seq_recognizer
   import fc_link_pkg::*;
#(
   parameter int unsigned REC_N = REC_COUNT
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic os_valid,
   input  os_code_t  os_code,
   input  wire logic data_ind,
   seq_rec_if.src    rec
);
   localparam int unsigned CW = $clog2(REC_N + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(REC_N);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   generate
      if (REC_N < 2) begin : g_bad
         $error("REC_N must be at least 2");
      end
   endgenerate

   function automatic logic is_sequence(input os_code_t c);
      return (c == OS_NOS) || (c == OS_OLS) || (c == OS_LR) ||
             (c == OS_LRR);
   endfunction : is_sequence

   os_code_t      prev_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (data_ind) begin
         cnt_d = '0;
      end else if (os_valid) begin
         if (os_code == prev_q && cnt_q != '0) begin
            cnt_d = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + CNT_ONE;
         end else begin
            cnt_d = CNT_ONE;
         end
      end
   end

   // run of identical sets, broken by any data word
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q  <= '0;
         prev_q <= OS_IDLE;
      end else begin
         cnt_q <= cnt_d;
         if (os_valid) begin
            prev_q <= os_code;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rec.rec_valid <= 1'b0;
         rec.rec_code  <= OS_IDLE;
      end else begin
         rec.rec_valid <= 1'b0;
         if (os_valid && !data_ind) begin
            if (is_sequence(os_code)) begin
               rec.rec_valid <= (cnt_d == CNT_MAX);
               rec.rec_code  <= os_code;
            end else if (os_code == OS_RRDY) begin
               rec.rec_valid <= 1'b1;
               rec.rec_code  <= OS_RRDY;
            end else if (os_code == OS_IDLE || os_code == OS_OTHER) begin
               // unknown sets count as idles
               rec.rec_valid <= 1'b1;
               rec.rec_code  <= OS_IDLE;
            end
         end
      end
   end

endmodule : seq_recognizer

// ==== peer_port.sv ====
// peer port model: streams ordered sets toward the port machine
// assumes tx_sel comes from the port under test, controls change at negedge
`timescale 1ns/1ps
module peer_port
   import fc_link_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  tx_sel_t         tx_sel,
   input  wire logic       auto_en,
   input  wire logic [7:0] resp_dly,
   input  os_code_t        man_code,
   input  wire logic       gap_en,
   input  wire logic       los_req,
   output logic            os_valid,
   output os_code_t        os_code,
   output logic            data_ind,
   output logic            loss_of_signal
);
   tx_sel_t    seen_q;
   logic [7:0] wait_q;
   logic [1:0] run_q;
   os_code_t   cur_q;

   // what a well behaved peer sends back to each stream it sees
   function automatic os_code_t answer(input tx_sel_t s);
      case (s)
         TX_LR:   answer = OS_LRR;
         TX_NOS:  answer = OS_OLS;
         TX_OLS:  answer = OS_LR;
         default: answer = OS_IDLE;
      endcase
   endfunction : answer

   always @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         seen_q         <= TX_IDLE;
         wait_q         <= 8'h00;
         run_q          <= 2'h0;
         cur_q          <= OS_IDLE;
         os_valid       <= 1'h0;
         os_code        <= OS_IDLE;
         data_ind       <= 1'h0;
         loss_of_signal <= 1'h0;
      end else begin
         seen_q <= tx_sel;
         if (tx_sel !== seen_q)
            wait_q <= 8'h00;
         else if (wait_q < resp_dly)
            wait_q <= wait_q + 8'h01;
         if (!auto_en)
            cur_q <= man_code;
         else if (tx_sel === seen_q && wait_q >= resp_dly)
            cur_q <= answer(tx_sel);
         run_q <= (run_q == 2'h2) ? 2'h0 : run_q + 2'h1;
         loss_of_signal <= los_req;
         // gap mode puts a data word in every third slot
         if (los_req || (gap_en && run_q == 2'h2)) begin
            os_valid <= 1'h0;
            data_ind <= !los_req;
            os_code  <= os_code_t'(~os_code);
         end else begin
            os_valid <= 1'h1;
            data_ind <= 1'h0;
            os_code  <= cur_q;
         end
      end
   end
endmodule : peer_port

// ==== test_link_recovery_fsm.sv ====
// testbench for the link recovery port machine with a peer port model
// assumes short hold and recovery counts set at the instance
`timescale 1ns/1ps
module test_link_recovery_fsm;
   import fc_link_pkg::*;
   localparam int OLS_N = 20;
   localparam int RTT_N = 50;
   logic        sys_clk, rst, los_req, gap_en, auto_en, diag_req;
   logic        init_req, pd_req;
   logic [2:0]  lr_req;
   logic [7:0]  resp_dly;
   os_code_t    man_code, os_code;
   logic        os_valid, data_ind, loss_of_signal;
   tx_sel_t     tx_sel;
   port_state_t port_state;
   logic        link_fail, rtt_timeout, lesb_proto_err, conn_remove;
   logic        ee_credit_reload, bb_credit_reload, class1_abort;
   logic        class1_discard, rx_flush;
   int          mismatches, total_checks, cyc;

   link_recovery_fsm #(.OLS_MIN(OLS_N), .RTT(RTT_N)) uut (
      .sys_clk, .rst, .os_valid, .os_code, .data_ind, .loss_of_signal,
      .link_init_req(init_req), .diag_req, .power_down_req(pd_req),
      .link_reset_req(lr_req[0]), .link_timeout_req(lr_req[1]),
      .conn_unknown_req(lr_req[2]), .tx_sel, .port_state, .link_fail,
      .rtt_timeout, .lesb_proto_err, .conn_remove, .ee_credit_reload,
      .bb_credit_reload, .class1_abort, .class1_discard, .rx_flush);

   peer_port peer (.sys_clk, .rst, .tx_sel, .auto_en, .resp_dly, .man_code,
      .gap_en, .los_req, .os_valid, .os_code, .data_ind, .loss_of_signal);

   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic chk_state(input port_state_t exp);
      total_checks++;
      if (port_state !== exp) begin
         mismatches++;
         $display("ERROR port_state expected %s seen %s", exp.name(),
                  port_state.name());
      end
   endtask : chk_state

   task automatic chk_tx(input tx_sel_t exp);
      total_checks++;
      if (tx_sel !== exp) begin
         mismatches++;
         $display("ERROR tx_sel expected %s seen %s", exp.name(),
                  tx_sel.name());
      end
   endtask : chk_tx

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk_bit

   task automatic chk_count(input string nm, input int exp, input int got);
      total_checks++;
      if (got != exp) begin
         mismatches++;
         $display("ERROR %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_count

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : step

   task automatic wait_state(input port_state_t exp, input int max);
      int n;
      n = 0;
      while (port_state !== exp && n < max) begin
         step(1);
         n++;
      end
      chk_state(exp);
   endtask : wait_state

   task automatic t_bring_up();
      chk_state(ST_OLS_TX);
      chk_tx(TX_OLS);
      auto_en = 1'h1;
      step(OLS_N - 4);
      chk_state(ST_OLS_TX);
      wait_state(ST_LR_RX, 12);
      chk_tx(TX_LRR);
      chk_bit("rx_flush", 1'h1, rx_flush);
      wait_state(ST_ACTIVE, 20);
      chk_tx(TX_IDLE);
      auto_en = 1'h0;
      $display("test bring_up done");
   endtask : t_bring_up

   task automatic t_active_stay();
      os_code_t codes[4] = '{OS_RRDY, OS_SOF, OS_EOF, OS_OTHER};
      foreach (codes[i]) begin
         man_code = codes[i];
         step(6);
         chk_state(ST_ACTIVE);
      end
      man_code = OS_LR;
      gap_en = 1'h1;
      step(12);
      chk_state(ST_ACTIVE);
      chk_tx(TX_IDLE);
      man_code = OS_IDLE;
      step(2);
      gap_en = 1'h0;
      $display("test active_stay done");
   endtask : t_active_stay

   task automatic t_lrr_active();
      man_code = OS_LRR;
      wait_state(ST_LRR_RX, 10);
      chk_bit("lesb_proto_err", 1'h1, lesb_proto_err);
      chk_tx(TX_IDLE);
      man_code = OS_LR;
      wait_state(ST_LR_RX, 10);
      man_code = OS_IDLE;
      wait_state(ST_ACTIVE, 10);
      $display("test lrr_active done");
   endtask : t_lrr_active

   task automatic t_link_reset();
      for (int i = 0; i < 3; i++) begin
         lr_req[i] = 1'h1;
         wait_state(ST_LR_TX, 3);
         lr_req[i] = 1'h0;
         chk_tx(TX_LR);
         chk_bit("class1_discard", 1'h1, class1_discard);
         chk_bit("class1_abort", 1'h1, class1_abort);
         chk_bit("conn_remove", 1'h1, conn_remove);
         chk_bit("ee_credit_reload", 1'h1, ee_credit_reload);
         chk_bit("bb_credit_reload", 1'h1, bb_credit_reload);
         step(8);
         chk_state(ST_LR_TX);
         resp_dly = 8'(2 + 8 * i);
         auto_en = 1'h1;
         wait_state(ST_LRR_RX, 40);
         chk_bit("class1_discard", 1'h0, class1_discard);
         wait_state(ST_ACTIVE, 40);
         auto_en = 1'h0;
      end
      $display("test link_reset done");
   endtask : t_link_reset

   task automatic t_timeout();
      int n;
      n = 0;
      lr_req[0] = 1'h1;
      wait_state(ST_LR_TX, 3);
      lr_req[0] = 1'h0;
      while (port_state === ST_LR_TX && n < RTT_N + 10) begin
         step(1);
         n++;
      end
      chk_count("cycles_in_lr_tx", RTT_N + 1, n);
      chk_state(ST_NOS_TX);
      chk_bit("link_fail", 1'h1, link_fail);
      chk_bit("rtt_timeout", 1'h1, rtt_timeout);
      chk_tx(TX_NOS);
      man_code = OS_LRR;
      step(10);
      chk_state(ST_NOS_TX);
      man_code = OS_LR;
      step(10);
      chk_state(ST_NOS_TX);
      man_code = OS_NOS;
      wait_state(ST_NOS_RX, 10);
      chk_tx(TX_OLS);
      man_code = OS_LRR;
      step(10);
      chk_state(ST_NOS_RX);
      man_code = OS_LR;
      wait_state(ST_LR_RX, 10);
      man_code = OS_IDLE;
      wait_state(ST_ACTIVE, 10);
      $display("test timeout done");
   endtask : t_timeout

   task automatic t_los();
      man_code = OS_LR;
      wait_state(ST_LR_RX, 10);
      step(4);
      chk_state(ST_LR_RX);
      los_req = 1'h1;
      wait_state(ST_NOS_TX, 6);
      chk_bit("link_fail", 1'h1, link_fail);
      los_req = 1'h0;
      man_code = OS_NOS;
      wait_state(ST_NOS_RX, 12);
      man_code = OS_IDLE;
      step(4);
      diag_req = 1'h1;
      wait_state(ST_OLS_TX, 3);
      diag_req = 1'h0;
      chk_tx(TX_OLS);
      step(OLS_N + 5);
      chk_state(ST_OLS_TX);
      chk_tx(TX_OLS);
      $display("test los_offline done");
   endtask : t_los

   // offline port asked to initialise, peer silent, then recovery path
   task automatic t_init();
      int n;
      n = 0;
      init_req = 1'h1;
      step(1);
      init_req = 1'h0;
      while (port_state === ST_OLS_TX && n < OLS_N + RTT_N + 10) begin
         step(1);
         n++;
      end
      chk_count("cycles_in_ols_tx", OLS_N + RTT_N + 1, n);
      chk_state(ST_WAIT_OLS);
      chk_tx(TX_NOS);
      man_code = OS_LRR;
      wait_state(ST_NOS_TX, 10);
      man_code = OS_OLS;
      wait_state(ST_OLS_RX, 10);
      chk_tx(TX_LR);
      man_code = OS_LRR;
      wait_state(ST_LRR_RX, 10);
      man_code = OS_IDLE;
      wait_state(ST_ACTIVE, 10);
      pd_req = 1'h1;
      wait_state(ST_OLS_TX, 3);
      pd_req = 1'h0;
      chk_tx(TX_OLS);
      $display("test init_offline done");
   endtask : t_init

   initial begin
      rst = 1'h1;
      {los_req, gap_en, auto_en, diag_req, init_req, pd_req} = 6'h00;
      lr_req = 3'h0;
      resp_dly = 8'h02;
      man_code = OS_IDLE;
      mismatches = 0;
      total_checks = 0;
      step(3);
      rst = 1'h0;
      t_bring_up();
      t_active_stay();
      t_lrr_active();
      t_link_reset();
      t_timeout();
      t_los();
      t_init();
      give_verdict();
   end
endmodule : test_link_recovery_fsm
